// >>> design/mag_cfg_thresh.sv
// Operation
// - four-bit channel code picks converted axes
// - codes 8 to B repeat an axis
// - idle interval applies only in wake-sleep
// - idle code maps to fixed milliseconds
// - one or four crossings raise event
// - direction bit picks above or below
// - gain goes to first or second axis
// - angle pair selects axes or disables
// - bit one doubles X and Y range
// - bit zero doubles Z range
// - X limit is signed range-scaled code
// - Y limit scaled like X limit
// - all registers clear to zero on reset
// - power state encodes four modes
// - shape zero signed, one magnitude pair
//
// magnetic axis configuration, conversion sequencing and threshold
// events; assumes a register port from the serial slave, an analog
// front end answering each request, and both on the core clock
`timescale 1ns/10ps
`include "mag_cfg_map.svh"

module mag_cfg_thresh #(
   parameter int unsigned cycles_per_ms = `NS_PER_MS / `CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [1:0] power_state_i,
   input wire logic [2:0] threshold_shape_i,
   input wire logic trigger_i,
   output logic convert_req_o,
   output logic [1:0] convert_axis_o,
   input wire logic convert_done_i,
   input wire logic [11:0] result_i,
   output logic threshold_event_o,
   output logic angle_enable_o,
   output logic [1:0] angle_first_axis_o,
   output logic [1:0] angle_second_axis_o,
   output logic [1:0] gain_axis_o,
   output logic xy_range_o,
   output logic z_range_o
);

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [7:0] chan_idle_cfg, next_chan_idle_cfg;
   logic [7:0] thr_cfg, next_thr_cfg;
   logic [7:0] x_limit_code, next_x_limit_code;
   logic [7:0] y_limit_code, next_y_limit_code;
   logic [7:0] next_rdata;

   always_comb begin
      next_chan_idle_cfg = chan_idle_cfg;
      next_thr_cfg = thr_cfg;
      next_x_limit_code = x_limit_code;
      next_y_limit_code = y_limit_code;
      next_rdata = reg_rdata_o;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `OFS_CHANNEL_AND_IDLE: next_chan_idle_cfg = reg_wdata_i;
            `OFS_THRESH_ANGLE_RANGE:
               next_thr_cfg = reg_wdata_i & `CFG2_WRITE_MASK;
            `OFS_X_AXIS_LIMIT: next_x_limit_code = reg_wdata_i;
            `OFS_Y_AXIS_LIMIT: next_y_limit_code = reg_wdata_i;
            default: next_rdata = reg_rdata_o;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `OFS_CHANNEL_AND_IDLE: next_rdata = chan_idle_cfg;
            `OFS_THRESH_ANGLE_RANGE: next_rdata = thr_cfg;
            `OFS_X_AXIS_LIMIT: next_rdata = x_limit_code;
            `OFS_Y_AXIS_LIMIT: next_rdata = y_limit_code;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         chan_idle_cfg <= `REG_RESET;
         thr_cfg <= `REG_RESET;
         x_limit_code <= `REG_RESET;
         y_limit_code <= `REG_RESET;
         reg_rdata_o <= 8'h00;
      end else begin
         chan_idle_cfg <= next_chan_idle_cfg;
         thr_cfg <= next_thr_cfg;
         x_limit_code <= next_x_limit_code;
         y_limit_code <= next_y_limit_code;
         reg_rdata_o <= next_rdata;
      end
   end

   // ****************************************************************
   // field decode
   // ****************************************************************
   logic [3:0] channel_code;
   logic [3:0] idle_interval_select;
   logic crossing_count_select;
   logic threshold_direction;
   logic gain_axis_select;
   logic [1:0] angle_pair;

   assign channel_code = chan_idle_cfg[`CH_SEL_HI:`CH_SEL_LO];
   assign idle_interval_select = chan_idle_cfg[`IDLE_SEL_HI:`IDLE_SEL_LO];
   assign crossing_count_select = thr_cfg[`CROSS_CNT_BIT];
   assign threshold_direction = thr_cfg[`DIR_BIT];
   assign gain_axis_select = thr_cfg[`GAIN_AXIS_BIT];
   assign angle_pair = thr_cfg[`ANGLE_HI:`ANGLE_LO];
   assign xy_range_o = thr_cfg[`XY_RANGE_BIT];
   assign z_range_o = thr_cfg[`Z_RANGE_BIT];

   always_comb begin
      angle_enable_o = 1'b1;
      unique case (angle_pair)
         2'h1: begin
            angle_first_axis_o = mag_cfg_pkg::AXIS_X;
            angle_second_axis_o = mag_cfg_pkg::AXIS_Y;
         end
         2'h2: begin
            angle_first_axis_o = mag_cfg_pkg::AXIS_Y;
            angle_second_axis_o = mag_cfg_pkg::AXIS_Z;
         end
         2'h3: begin
            angle_first_axis_o = mag_cfg_pkg::AXIS_X;
            angle_second_axis_o = mag_cfg_pkg::AXIS_Z;
         end
         2'h0: begin
            angle_enable_o = 1'b0;
            angle_first_axis_o = mag_cfg_pkg::AXIS_NONE;
            angle_second_axis_o = mag_cfg_pkg::AXIS_NONE;
         end
      endcase
      gain_axis_o = gain_axis_select ? angle_second_axis_o
                                     : angle_first_axis_o;
   end

   // ****************************************************************
   // channel sequence table
   // ****************************************************************
   logic [5:0] seq_axes;
   logic [1:0] seq_len;

   always_comb begin
      seq_len = 2'h3;
      unique case (channel_code)
         4'h1: {seq_len, seq_axes} = {2'h1, 6'b00_00_01};
         4'h2: {seq_len, seq_axes} = {2'h1, 6'b00_00_10};
         4'h3: {seq_len, seq_axes} = {2'h2, 6'b00_10_01};
         4'h4: {seq_len, seq_axes} = {2'h1, 6'b00_00_11};
         4'h5: {seq_len, seq_axes} = {2'h2, 6'b00_11_01};
         4'h6: {seq_len, seq_axes} = {2'h2, 6'b00_11_10};
         4'h7: seq_axes = 6'b11_10_01;
         4'h8: seq_axes = 6'b01_10_01;
         4'h9: seq_axes = 6'b10_01_10;
         4'hA: seq_axes = 6'b10_11_10;
         4'hB: seq_axes = 6'b01_11_01;
         default: {seq_len, seq_axes} = {2'h0, 6'b00_00_00};
      endcase
   end

   // ****************************************************************
   // conversion sequencer
   // ****************************************************************
   mag_cfg_pkg::seq_state_t state, next_state;
   logic [1:0] idx, next_idx;
   logic start_ok;
   logic timer_start;
   logic timer_done;
   logic wake_sleep;

   assign wake_sleep = power_state_i == `POWER_WAKE_SLEEP;

   always_comb begin
      unique case (mag_cfg_pkg::power_t'(power_state_i))
         mag_cfg_pkg::PWR_STANDBY: start_ok = trigger_i;
         mag_cfg_pkg::PWR_SLEEP: start_ok = 1'b0;
         mag_cfg_pkg::PWR_CONTINUOUS: start_ok = 1'b1;
         mag_cfg_pkg::PWR_WAKE_SLEEP: start_ok = 1'b1;
      endcase
   end

   assign convert_req_o = state == mag_cfg_pkg::ST_CONVERT;
   assign convert_axis_o = convert_req_o ? seq_axes[idx*2 +: 2] : 2'h0;

   always_comb begin
      next_state = state;
      next_idx = idx;
      timer_start = 1'b0;
      unique case (state)
         mag_cfg_pkg::ST_IDLE: begin
            if (start_ok && seq_len != 2'h0) begin
               next_state = mag_cfg_pkg::ST_CONVERT;
               next_idx = 2'h0;
            end
         end
         mag_cfg_pkg::ST_CONVERT: begin
            if (convert_done_i) begin
               if (idx == seq_len - 2'h1) begin
                  next_idx = 2'h0;
                  if (wake_sleep) begin
                     next_state = mag_cfg_pkg::ST_WAIT;
                     timer_start = 1'b1;
                  end else begin
                     next_state = mag_cfg_pkg::ST_IDLE;
                  end
               end else begin
                  next_idx = idx + 2'h1;
               end
            end
         end
         mag_cfg_pkg::ST_WAIT: begin
            if (timer_done || !wake_sleep) begin
               next_state = mag_cfg_pkg::ST_IDLE;
            end
         end
         default: next_state = mag_cfg_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= mag_cfg_pkg::ST_IDLE;
         idx <= 2'h0;
      end else begin
         state <= next_state;
         idx <= next_idx;
      end
   end

   idle_timer #(
      .cycles_per_ms(cycles_per_ms)
   ) u_idle_timer (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .start_i(timer_start),
      .code_i(idle_interval_select),
      .done_o(timer_done)
   );

   // ****************************************************************
   // per-axis limit check
   // ****************************************************************
   logic [1:0] met_q;
   logic [1:0] crossing;
   logic signed [8:0] sample9;

   // top eight bits of a full-scale sample step by range/128
   assign sample9 = {result_i[11], result_i[11:4]};

   for (genvar g = 0; g < 2; g++) begin : g_axis
      logic [7:0] code;
      logic signed [8:0] lim9;
      logic signed [8:0] mag9;
      logic hit;
      logic met, next_met;
      logic sampled;

      assign code = (g == 0) ? x_limit_code : y_limit_code;
      assign lim9 = {code[7], code};
      assign mag9 = {2'b00, code[6:0]};
      assign sampled = convert_done_i && convert_req_o
         && convert_axis_o == ((g == 0) ? 2'h1 : 2'h2);

      always_comb begin
         hit = 1'b0;
         if (code != 8'h00) begin
            unique case (threshold_shape_i)
               `SHAPE_SIGNED: hit = threshold_direction ?
                  (sample9 < lim9) : (sample9 > lim9);
               `SHAPE_MAGNITUDE: hit = (sample9 > mag9)
                  || (sample9 < -mag9);
               default: hit = 1'b0;
            endcase
         end
         next_met = sampled ? hit : met;
      end

      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            met <= 1'b0;
         end else begin
            met <= next_met;
         end
      end

      assign met_q[g] = met;
      assign crossing[g] = sampled && hit && !met;
   end

   // ****************************************************************
   // crossing counter
   // ****************************************************************
   logic [2:0] cross_cnt, next_cross_cnt;
   logic [2:0] cross_need;
   logic next_event;

   assign cross_need = crossing_count_select ? `CROSS_MANY
                                             : `CROSS_ONE;

   always_comb begin
      next_cross_cnt = cross_cnt;
      next_event = 1'b0;
      if (crossing != 2'b00) begin
         if (cross_cnt + 3'h1 >= cross_need) begin
            next_cross_cnt = 3'h0;
            next_event = 1'b1;
         end else begin
            next_cross_cnt = cross_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cross_cnt <= 3'h0;
         threshold_event_o <= 1'b0;
      end else begin
         cross_cnt <= next_cross_cnt;
         threshold_event_o <= next_event;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_reset_clear;
      @(posedge clk_i) reset_i |=> (chan_idle_cfg == 8'h00
         && thr_cfg == 8'h00 && x_limit_code == 8'h00
         && y_limit_code == 8'h00);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("registers not cleared by reset");

   property p_single_x;
      @(posedge clk_i) disable iff (reset_i)
      (convert_req_o && channel_code == 4'h1) |-> convert_axis_o == 2'h1;
   endproperty
   a_single_x: assert property (p_single_x)
      else $error("code 1 did not convert X");

   property p_repeat_xyx;
      @(posedge clk_i) disable iff (reset_i)
      (convert_req_o && channel_code == 4'h8 && idx != 2'h1)
         |-> convert_axis_o == 2'h1;
   endproperty
   a_repeat_xyx: assert property (p_repeat_xyx)
      else $error("code 8 outer conversions not X");

   property p_reserved_idle;
      @(posedge clk_i) disable iff (reset_i)
      (state == mag_cfg_pkg::ST_IDLE && channel_code >= `CH_FIRST_RESERVED)
         |=> !convert_req_o;
   endproperty
   a_reserved_idle: assert property (p_reserved_idle)
      else $error("reserved channel code started a conversion");

   property p_wait_only_ws;
      @(posedge clk_i) disable iff (reset_i)
      $rose(state == mag_cfg_pkg::ST_WAIT) |-> $past(wake_sleep);
   endproperty
   a_wait_only_ws: assert property (p_wait_only_ws)
      else $error("idle wait outside wake-sleep mode");

   property p_zero_limit;
      @(posedge clk_i) disable iff (reset_i)
      (x_limit_code == 8'h00 && g_axis[0].sampled) |=> !met_q[0];
   endproperty
   a_zero_limit: assert property (p_zero_limit)
      else $error("zero limit still compared");

   property p_one_crossing;
      @(posedge clk_i) disable iff (reset_i)
      (crossing != 2'b00 && !crossing_count_select) |=> threshold_event_o;
   endproperty
   a_one_crossing: assert property (p_one_crossing)
      else $error("single crossing did not raise event");

   property p_four_crossing;
      @(posedge clk_i) disable iff (reset_i)
      (crossing != 2'b00 && crossing_count_select && cross_cnt < 3'h3)
         |=> !threshold_event_o;
   endproperty
   a_four_crossing: assert property (p_four_crossing)
      else $error("event before fourth crossing");

   property p_above;
      @(posedge clk_i) disable iff (reset_i)
      (g_axis[0].sampled && threshold_shape_i == `SHAPE_SIGNED
         && !threshold_direction && x_limit_code != 8'h00
         && sample9 > $signed({x_limit_code[7], x_limit_code}))
         |=> met_q[0];
   endproperty
   a_above: assert property (p_above)
      else $error("field above X limit not detected");

   property p_angle_off;
      @(posedge clk_i) disable iff (reset_i)
      (angle_pair == 2'h0) |-> (!angle_enable_o && gain_axis_o == 2'h0);
   endproperty
   a_angle_off: assert property (p_angle_off)
      else $error("angle active with pair code zero");

   c_wait: cover property (@(posedge clk_i) disable iff (reset_i)
      state == mag_cfg_pkg::ST_WAIT ##1 state == mag_cfg_pkg::ST_IDLE);
   c_event: cover property (@(posedge clk_i) disable iff (reset_i)
      threshold_event_o && crossing_count_select);
   c_repeat: cover property (@(posedge clk_i) disable iff (reset_i)
      convert_req_o && channel_code == 4'hB && idx == 2'h2);

endmodule : mag_cfg_thresh

// >>> design/mag_cfg_map.svh
// offsets, field positions, reset values and timing counts of the
// magnetic configuration block; assumes a 20 MHz core clock
`ifndef MAG_CFG_MAP_SVH
`define MAG_CFG_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CHANNEL_AND_IDLE 8'h02
`define OFS_THRESH_ANGLE_RANGE 8'h03
`define OFS_X_AXIS_LIMIT 8'h04
`define OFS_Y_AXIS_LIMIT 8'h05
`define REG_RESET 8'h00
`define CFG2_WRITE_MASK 8'h7F

// ****************************************************************
// field positions
// ****************************************************************
`define CH_SEL_HI 7
`define CH_SEL_LO 4
`define IDLE_SEL_HI 3
`define IDLE_SEL_LO 0
`define CROSS_CNT_BIT 6
`define DIR_BIT 5
`define GAIN_AXIS_BIT 4
`define ANGLE_HI 3
`define ANGLE_LO 2
`define XY_RANGE_BIT 1
`define Z_RANGE_BIT 0

// ****************************************************************
// codes and counts
// ****************************************************************
`define CH_FIRST_RESERVED 4'hC
`define POWER_WAKE_SLEEP 2'h3
`define SHAPE_SIGNED 3'h0
`define SHAPE_MAGNITUDE 3'h1
`define CROSS_MANY 3'h4
`define CROSS_ONE 3'h1

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 50
`define NS_PER_MS 1000000
`define IDLE_MS_0 15'h0001
`define IDLE_MS_1 15'h0005
`define IDLE_MS_2 15'h000A
`define IDLE_MS_3 15'h000F
`define IDLE_MS_4 15'h0014
`define IDLE_MS_5 15'h001E
`define IDLE_MS_6 15'h0032
`define IDLE_MS_7 15'h0064
`define IDLE_MS_8 15'h01F4
`define IDLE_MS_9 15'h03E8
`define IDLE_MS_A 15'h07D0
`define IDLE_MS_B 15'h01F4
`define IDLE_MS_C 15'h4E20

`endif

// >>> design/mag_cfg_pkg.sv
// types shared by the magnetic configuration block
// assumes nothing beyond a SystemVerilog compiler
package mag_cfg_pkg;

   // ****************************************************************
   // axis and state types
   // ****************************************************************
   typedef enum logic [1:0] {
      AXIS_NONE = 2'h0,
      AXIS_X = 2'h1,
      AXIS_Y = 2'h2,
      AXIS_Z = 2'h3
   } axis_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CONVERT = 2'h1,
      ST_WAIT = 2'h3
   } seq_state_t;

   typedef enum logic [1:0] {
      PWR_STANDBY = 2'h0,
      PWR_SLEEP = 2'h1,
      PWR_CONTINUOUS = 2'h2,
      PWR_WAKE_SLEEP = 2'h3
   } power_t;

endpackage : mag_cfg_pkg

// >>> design/idle_timer.sv
// idle interval timer between conversion sequences
// assumes start_i pulses once per interval on the core clock
`timescale 1ns/10ps
`include "mag_cfg_map.svh"

module idle_timer #(
   parameter int unsigned cycles_per_ms = `NS_PER_MS / `CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [3:0] code_i,
   output logic done_o
);

   // ****************************************************************
   // interval table
   // ****************************************************************
   function automatic logic [14:0] interval_ms(input logic [3:0] c);
      unique case (c)
         4'h0: interval_ms = `IDLE_MS_0;
         4'h1: interval_ms = `IDLE_MS_1;
         4'h2: interval_ms = `IDLE_MS_2;
         4'h3: interval_ms = `IDLE_MS_3;
         4'h4: interval_ms = `IDLE_MS_4;
         4'h5: interval_ms = `IDLE_MS_5;
         4'h6: interval_ms = `IDLE_MS_6;
         4'h7: interval_ms = `IDLE_MS_7;
         4'h8: interval_ms = `IDLE_MS_8;
         4'h9: interval_ms = `IDLE_MS_9;
         4'hA: interval_ms = `IDLE_MS_A;
         4'hB: interval_ms = `IDLE_MS_B;
         default: interval_ms = `IDLE_MS_C;
      endcase
   endfunction : interval_ms

   // ****************************************************************
   // counters
   // ****************************************************************
   logic busy, next_busy;
   logic [31:0] presc, next_presc;
   logic [14:0] ms_left, next_ms_left;
   logic next_done;

   always_comb begin
      next_busy = busy;
      next_presc = presc;
      next_ms_left = ms_left;
      next_done = 1'b0;
      if (start_i) begin
         next_busy = 1'b1;
         next_presc = 32'h0000_0000;
         next_ms_left = interval_ms(code_i);
      end else if (busy) begin
         if (presc == cycles_per_ms - 1) begin
            next_presc = 32'h0000_0000;
            next_ms_left = ms_left - 15'h0001;
            if (ms_left == 15'h0001) begin
               next_busy = 1'b0;
               next_done = 1'b1;
            end
         end else begin
            next_presc = presc + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         busy <= 1'b0;
         presc <= 32'h0000_0000;
         ms_left <= 15'h0000;
         done_o <= 1'b0;
      end else begin
         busy <= next_busy;
         presc <= next_presc;
         ms_left <= next_ms_left;
         done_o <= next_done;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_one_ms_interval;
      @(posedge clk_i) disable iff (reset_i)
      (start_i && code_i == 4'h0 && cycles_per_ms == 2)
         |-> ##3 done_o;
   endproperty
   a_one_ms_interval: assert property (p_one_ms_interval)
      else $error("idle interval of one ms not timed");

endmodule : idle_timer

// >>> tb/front_end_model.sv
// analog front end model answering conversion requests
// assumes requests and results on the core clock, driven at falling edge
`timescale 1ns/10ps
module front_end_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [1:0] axis_i,
   input wire logic [11:0] sample_i,
   input wire logic [3:0] lat_i,
   output logic done_o,
   output logic [11:0] result_o,
   output logic [7:0] log_o
);
   logic [3:0] wait_n = 4'h0;
   initial begin
      done_o = 1'b0;
      result_o = 12'h000;
      log_o = 8'h00;
   end
   // ****************************************************************
   // answer after lat_i cycles; result toggles when not valid
   // ****************************************************************
   always @(negedge clk_i) begin
      result_o <= ~result_o;
      done_o <= 1'b0;
      if (req_i && !done_o) begin
         if (wait_n >= lat_i) begin
            done_o <= 1'b1;
            result_o <= sample_i;
            log_o <= {log_o[5:0], axis_i};
            wait_n <= 4'h0;
         end else begin
            wait_n <= wait_n + 4'h1;
         end
      end
   end
endmodule : front_end_model

// >>> tb/mag_cfg_thresh_test.sv
// self-checking bench for the magnetic configuration block
// assumes the front end model and cycles_per_ms of 2
`timescale 1ns/10ps
module mag_cfg_thresh_test;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic rd = 1'b0;
   logic [2:0] shape = 3'h0;
   logic trig = 1'b0;
   logic [11:0] sample = 12'h000;
   logic [3:0] lat = 4'h0;
   logic [1:0] pwr = 2'h0;
   logic [7:0] rdata, log;
   logic req, done, ev, ang_en, xy_r, z_r;
   logic [1:0] axis, first, second, gain;
   logic [11:0] result;
   int err_total = 0;
   int compares = 0;
   int n_done = 0;
   int n_ev = 0;
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (done === 1'b1) n_done <= n_done + 1;
      if (ev === 1'b1) n_ev <= n_ev + 1;
   end
   mag_cfg_thresh #(.cycles_per_ms(2)) dut (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .reg_addr_i(addr),
      .reg_wr_i(wr),
      .reg_wdata_i(wdata),
      .reg_rd_i(rd),
      .reg_rdata_o(rdata),
      .power_state_i(pwr),
      .threshold_shape_i(shape),
      .trigger_i(trig),
      .convert_req_o(req),
      .convert_axis_o(axis),
      .convert_done_i(done),
      .result_i(result),
      .threshold_event_o(ev),
      .angle_enable_o(ang_en),
      .angle_first_axis_o(first),
      .angle_second_axis_o(second),
      .gain_axis_o(gain),
      .xy_range_o(xy_r),
      .z_range_o(z_r)
   );
   front_end_model fe (
      .clk_i(clk_i),
      .req_i(req),
      .axis_i(axis),
      .sample_i(sample),
      .lat_i(lat),
      .done_o(done),
      .result_o(result),
      .log_o(log)
   );
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
   endtask : wrt
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_i);
      addr = a;
      rd = 1'b1;
      @(negedge clk_i);
      rd = 1'b0;
      check({4'h0, rdata}, {4'h0, e});
   endtask : rdc
   task automatic run(input int cnt);
      int n0;
      n0 = n_done;
      @(negedge clk_i);
      trig = 1'b1;
      @(negedge clk_i);
      trig = 1'b0;
      for (int t = 0; t < 200 && n_done < n0 + cnt; t++) @(negedge clk_i);
      repeat (10) @(negedge clk_i);
      check(12'(n_done - n0), 12'(cnt));
   endtask : run
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic regs;
      for (int a = 2; a < 6; a++) rdc(8'(a), 8'h00);
      wrt(8'h02, 8'h71);
      rdc(8'h02, 8'h71);
      wrt(8'h06, 8'hAA);
      rdc(8'h06, 8'h00);
      wrt(8'h03, 8'hFF);
      rdc(8'h03, 8'h7F);
      check({3'h0, ang_en, first, second, gain, xy_r, z_r}, 12'h17F);
      wrt(8'h03, 8'h04);
      check({3'h0, ang_en, first, second, gain, xy_r, z_r}, 12'h164);
      wrt(8'h03, 8'h0A);
      check({3'h0, ang_en, first, second, gain, xy_r, z_r}, 12'h1BA);
   endtask : regs
   task automatic seqs;
      logic [7:0] exp [11] = '{8'h01, 8'h02, 8'h06, 8'h03, 8'h07, 8'h0B,
         8'h1B, 8'h19, 8'h26, 8'h2E, 8'h1D};
      int cnt [11] = '{1, 1, 2, 1, 2, 2, 3, 3, 3, 3, 3};
      for (int i = 0; i < 11; i++) begin
         lat = 4'((i % 2) * 3);
         wrt(8'h02, {4'(i + 1), 4'h0});
         run(cnt[i]);
         check({4'h0, log & 8'((1 << (2 * cnt[i])) - 1)}, {4'h0, exp[i]});
      end
      lat = 4'h0;
      wrt(8'h02, 8'hC0);
      run(0);
      wrt(8'h02, 8'h00);
      run(0);
   endtask : seqs
   task automatic conv(input logic [11:0] s, input int e);
      sample = s;
      run(1);
      check(12'(n_ev), 12'(e));
   endtask : conv
   task automatic thresh;
      wrt(8'h02, 8'h10);
      wrt(8'h04, 8'h10);
      wrt(8'h03, 8'h00);
      conv(12'h200, 1);
      conv(12'h200, 1);
      conv(12'h000, 1);
      wrt(8'h03, 8'h20);
      conv(12'h000, 2);
      wrt(8'h03, 8'h40);
      conv(12'h000, 2);
      for (int i = 0; i < 3; i++) begin
         conv(12'h200, 2);
         conv(12'h000, 2);
      end
      conv(12'h200, 3);
      wrt(8'h03, 8'h00);
      wrt(8'h04, 8'h00);
      conv(12'h000, 3);
      conv(12'h200, 3);
      shape = 3'h1;
      wrt(8'h04, 8'h10);
      conv(12'h000, 3);
      conv(12'hE00, 4);
      shape = 3'h2;
      conv(12'h000, 4);
      conv(12'hE00, 4);
   endtask : thresh
   // cycles between two conversion ends in one power state
   task automatic gap(input logic [1:0] p, input logic [7:0] cfg,
      input int e);
      int n0;
      int t;
      wrt(8'h02, cfg);
      pwr = p;
      t = 0;
      for (int k = 0; k < 2; k++) begin
         n0 = n_done;
         for (t = 0; t < 100 && n_done == n0; t++) @(negedge clk_i);
      end
      pwr = 2'h0;
      repeat (10) @(negedge clk_i);
      check(12'(t), 12'(e));
   endtask : gap
   // ****************************************************************
   // verdict and run control
   // ****************************************************************
   task automatic summarize;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   initial begin
      #2000000;
      err_total++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      regs();
      seqs();
      gap(2'h2, 8'h11, 2);
      gap(2'h3, 8'h10, 5);
      gap(2'h3, 8'h11, 13);
      gap(2'h1, 8'h10, 100);
      thresh();
      summarize();
   end
endmodule : mag_cfg_thresh_test
